// *** hdl/sideband_ctrl.sv ***
// sideband pins and two-wire management port of a four-lane pluggable module
// assumes scl/sda come from the host; scl is the link domain clock and may stop between frames
`timescale 1ns/1ps
`default_nettype none
module sideband_ctrl #(
	parameter longint RESET_MIN = sideband_pkg::RESET_MIN_CYCLES,
	parameter longint INIT_WAIT = sideband_pkg::INIT_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       module_select_n,
	input  wire logic       module_reset_n,
	input  wire logic       low_power_select,
	input  wire logic [3:0] lane_fault,
	input  wire logic [7:0] temp_in,
	input  wire logic [7:0] supply_in,
	output logic            attention_n,
	output logic            attention_oe,
	output logic            module_present_n,
	output logic            module_present_oe,
	output logic [3:0]      lane_tx_enable,
	output logic            power_limit,
	output logic            data_not_ready
);
	localparam logic [sideband_pkg::CNT_W-1:0] RST_MIN_C = RESET_MIN[sideband_pkg::CNT_W-1:0];
	localparam logic [sideband_pkg::CNT_W-1:0] INIT_END  = INIT_WAIT[sideband_pkg::CNT_W-1:0] - 1'b1;

	// ---------------- link domain (scl) ----------------
	sideband_pkg::link_phase_type phase;
	logic       start_tog;
	logic       start_seen;
	logic       sel;
	logic       rw;
	logic [7:0] shift;
	logic [7:0] ptr;
	logic [7:0] tx;
	logic [3:0] bit_cnt;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic       wr_tog;
	logic       rd_tog;
	logic       addr_hit;
	logic [7:0] rd_byte;
	logic       link_busy;

	// mclk-side snapshot, frozen during address, pointer and read phases so the link reads stable words
	logic [7:0] snap_status;
	logic [4:0] snap_flags;
	logic [7:0] snap_temp;
	logic [7:0] snap_supply;
	logic [3:0] snap_chan;
	logic       snap_hp;

	// a start is sda falling with scl high; a toggle carries it into the scl domain
	always_ff @(negedge sda_in or posedge rst) begin
		if (rst)
			start_tog <= 1'b0;
		else if (scl)
			start_tog <= ~start_tog;
	end

	assign addr_hit = sel && (shift[7:1] == sideband_pkg::DEV_ADDR);

	always_comb begin
		unique case (ptr)
			sideband_pkg::OFS_STATUS: rd_byte = snap_status;
			sideband_pkg::OFS_FLAGS:  rd_byte = {snap_flags[4:1], 3'h0, snap_flags[0]};
			sideband_pkg::OFS_TEMP:   rd_byte = snap_temp;
			sideband_pkg::OFS_SUPPLY: rd_byte = snap_supply;
			sideband_pkg::OFS_CHAN:   rd_byte = {4'h0, snap_chan};
			sideband_pkg::OFS_POWER:  rd_byte = {7'h00, snap_hp};
			default:                  rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			phase      <= sideband_pkg::ph_idle;
			start_seen <= 1'b0;
			sel        <= 1'b0;
			rw         <= 1'b0;
			shift      <= 8'h00;
			ptr        <= 8'h00;
			tx         <= 8'h00;
			bit_cnt    <= 4'h0;
			wr_addr    <= 8'h00;
			wr_data    <= 8'h00;
			wr_tog     <= 1'b0;
			rd_tog     <= 1'b0;
		end else if (start_tog != start_seen) begin
			start_seen <= start_tog;
			phase      <= sideband_pkg::ph_addr;
			sel        <= ~module_select_n;
			shift      <= {7'h00, sda_in};
			bit_cnt    <= 4'h1;
		end else if (phase != sideband_pkg::ph_idle) begin
			if (bit_cnt != 4'h8) begin
				shift   <= {shift[6:0], sda_in};
				bit_cnt <= bit_cnt + 4'h1;
			end else begin
				bit_cnt <= 4'h0;
				unique case (phase)
					sideband_pkg::ph_addr: begin
						rw <= shift[0];
						if (!addr_hit)
							phase <= sideband_pkg::ph_idle;
						else if (shift[0]) begin
							phase  <= sideband_pkg::ph_rdata;
							tx     <= rd_byte;
							ptr    <= ptr + 8'h01;
							rd_tog <= (ptr == sideband_pkg::OFS_FLAGS) ? ~rd_tog : rd_tog;
						end else
							phase <= sideband_pkg::ph_ptr;
					end
					sideband_pkg::ph_ptr: begin
						ptr   <= shift;
						phase <= sideband_pkg::ph_wdata;
					end
					sideband_pkg::ph_wdata: begin
						wr_addr <= ptr;
						wr_data <= shift;
						wr_tog  <= ~wr_tog;
						ptr     <= ptr + 8'h01;
					end
					sideband_pkg::ph_rdata: begin
						// host nack ends the read
						if (sda_in)
							phase <= sideband_pkg::ph_idle;
						else begin
							tx     <= rd_byte;
							ptr    <= ptr + 8'h01;
							rd_tog <= (ptr == sideband_pkg::OFS_FLAGS) ? ~rd_tog : rd_tog;
						end
					end
					default: phase <= sideband_pkg::ph_idle;
				endcase
			end
		end
	end

	// data line changes only while scl is low
	always_ff @(negedge scl or posedge rst) begin
		if (rst) begin
			sda_oe  <= 1'b0;
			sda_out <= 1'b0;
		end else if (start_tog != start_seen)
			sda_oe <= 1'b0;
		else if (bit_cnt == 4'h8)
			sda_oe <= (phase == sideband_pkg::ph_addr && addr_hit) ||
			          phase == sideband_pkg::ph_ptr || phase == sideband_pkg::ph_wdata;
		else
			sda_oe <= phase == sideband_pkg::ph_rdata && !tx[3'h7 - bit_cnt[2:0]];
	end

	// registered so no decode glitch reaches the synchroniser; the write phase has no
	// stop detect and lingers, so it must not freeze the snapshot or later reads go stale
	always_ff @(negedge scl or posedge rst) begin
		if (rst)
			link_busy <= 1'b0;
		else
			link_busy <= phase == sideband_pkg::ph_addr || phase == sideband_pkg::ph_ptr ||
			             phase == sideband_pkg::ph_rdata;
	end

	// ---------------- management domain (mclk) ----------------
	logic       s_reset_n;
	logic       s_lp;
	logic [3:0] s_fault;
	logic       s_freeze;
	logic       s_wr;
	logic       s_rd;
	logic       wr_seen;
	logic       rd_seen;
	logic [3:0] fault_prev;
	logic       wr_pulse;
	logic       rd_pulse;
	logic       long_low;
	logic       done_event;
	sideband_pkg::mod_state_type state;
	logic [sideband_pkg::CNT_W-1:0] low_cnt;
	logic [sideband_pkg::CNT_W-1:0] cnt;
	logic [3:0] chan_dis;
	logic       hp_en;
	logic [4:0] flags;

	sync_stage #(.W(9)) u_sync (
		.clk (mclk),
		.rst (rst),
		.d   ({module_reset_n, low_power_select, lane_fault, link_busy, wr_tog, rd_tog}),
		.q   ({s_reset_n, s_lp, s_fault, s_freeze, s_wr, s_rd})
	);

	assign wr_pulse   = s_wr ^ wr_seen;
	assign rd_pulse   = s_rd ^ rd_seen;
	assign long_low   = !s_reset_n && low_cnt == RST_MIN_C;
	assign done_event = state == sideband_pkg::st_init && cnt == INIT_END && !long_low;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_seen    <= 1'b0;
			rd_seen    <= 1'b0;
			fault_prev <= 4'h0;
		end else begin
			wr_seen    <= s_wr;
			rd_seen    <= s_rd;
			fault_prev <= s_fault;
		end
	end

	// a low shorter than the minimum never reaches the compare and is dropped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			low_cnt <= '0;
		else if (s_reset_n)
			low_cnt <= '0;
		else if (low_cnt != RST_MIN_C)
			low_cnt <= low_cnt + 1'b1;
	end

	// power-up enters init directly, so completion is posted with no reset pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= sideband_pkg::st_init;
			cnt   <= '0;
		end else begin
			unique case (state)
				sideband_pkg::st_reset: begin
					cnt <= '0;
					if (s_reset_n)
						state <= sideband_pkg::st_init;
				end
				sideband_pkg::st_init: begin
					if (long_low)
						state <= sideband_pkg::st_reset;
					else if (cnt == INIT_END)
						state <= sideband_pkg::st_ready;
					else
						cnt <= cnt + 1'b1;
				end
				sideband_pkg::st_ready: begin
					if (long_low)
						state <= sideband_pkg::st_reset;
				end
				default: state <= sideband_pkg::st_reset;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			chan_dis <= sideband_pkg::CHAN_DIS_RST;
			hp_en    <= sideband_pkg::HP_EN_RST;
		end else if (state == sideband_pkg::st_reset) begin
			chan_dis <= sideband_pkg::CHAN_DIS_RST;
			hp_en    <= sideband_pkg::HP_EN_RST;
		end else if (wr_pulse) begin
			if (wr_addr == sideband_pkg::OFS_CHAN)
				chan_dis <= wr_data[3:0];
			if (wr_addr == sideband_pkg::OFS_POWER)
				hp_en <= wr_data[0];
		end
	end

	// clear-on-read removes only the bits the host saw; a new event in that cycle still sets
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			flags <= sideband_pkg::FLAGS_RST;
		else if (state == sideband_pkg::st_reset)
			flags <= sideband_pkg::FLAGS_RST;
		else
			flags <= (flags & ~(rd_pulse ? snap_flags : 5'h00)) |
			         {s_fault & ~fault_prev, done_event};
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			snap_status <= 8'h01;
			snap_flags  <= sideband_pkg::FLAGS_RST;
			snap_temp   <= 8'h00;
			snap_supply <= 8'h00;
			snap_chan   <= sideband_pkg::CHAN_DIS_RST;
			snap_hp     <= sideband_pkg::HP_EN_RST;
		end else if (!s_freeze) begin
			snap_status <= {6'h00, power_limit, data_not_ready};
			snap_flags  <= flags;
			snap_temp   <= temp_in;
			snap_supply <= supply_in;
			snap_chan   <= chan_dis;
			snap_hp     <= hp_en;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			attention_n       <= 1'b0;
			attention_oe      <= 1'b0;
			module_present_n  <= 1'b0;
			module_present_oe <= 1'b1;
			lane_tx_enable    <= 4'h0;
			power_limit       <= 1'b1;
			data_not_ready    <= 1'b1;
		end else begin
			attention_n       <= 1'b0;
			attention_oe      <= |flags;
			module_present_n  <= 1'b0;
			module_present_oe <= 1'b1;
			lane_tx_enable    <= (state == sideband_pkg::st_ready) ? ~chan_dis : 4'h0;
			power_limit       <= s_lp | ~hp_en;
			data_not_ready    <= state != sideband_pkg::st_ready;
		end
	end
endmodule : sideband_ctrl
`default_nettype wire

// *** hdl/sideband_pkg.sv ***
// constants, map offsets and state type for the pluggable module sideband control
// assumes a 125 MHz management clock and a host-clocked two-wire link
package sideband_pkg;

	localparam logic [6:0] DEV_ADDR = 7'h50;

	// two-wire memory map offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_FLAGS  = 8'h01;
	localparam logic [7:0] OFS_TEMP   = 8'h02;
	localparam logic [7:0] OFS_SUPPLY = 8'h03;
	localparam logic [7:0] OFS_CHAN   = 8'h04;
	localparam logic [7:0] OFS_POWER  = 8'h05;

	// field positions
	localparam int STS_NOT_READY = 0;
	localparam int STS_LOW_POWER = 1;
	localparam int FLG_RESET_DONE = 0;
	localparam int FLG_LANE_LSB   = 4;

	// values after reset
	localparam logic [3:0] CHAN_DIS_RST = 4'h0;
	localparam logic       HP_EN_RST    = 1'b0;
	localparam logic [4:0] FLAGS_RST    = 5'h00;

	// timing
	localparam longint MCLK_PERIOD_NS   = 8;
	localparam longint RESET_MIN_NS     = 10000;
	localparam longint RESET_MIN_CYCLES = (RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam longint INIT_TIME_MS     = 2000;
	localparam longint INIT_CYCLES      = INIT_TIME_MS * 64'd1000000 / MCLK_PERIOD_NS;
	localparam int     CNT_W            = 28;

	typedef enum logic [1:0] {
		st_reset = 2'b00,
		st_init  = 2'b01,
		st_ready = 2'b10
	} mod_state_type;

	typedef enum logic [2:0] {
		ph_idle  = 3'b000,
		ph_addr  = 3'b001,
		ph_ptr   = 3'b010,
		ph_wdata = 3'b011,
		ph_rdata = 3'b100
	} link_phase_type;

endpackage : sideband_pkg

// *** hdl/sync_stage.sv ***
// two flip-flop level synchroniser, any width
// assumes each bit is an independent level or a toggle
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : sync_stage
`default_nettype wire

// *** test/host_link_model.sv ***
// host-side two-wire master model with a pulled-up data line
// assumes the tb calls its tasks; scl idles high between frames
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda_in
);
	logic hold_low = 1'b0;
	initial scl = 1'b1;
	// pull-up: the line is low if either side pulls it
	assign sda_in = ~(hold_low | sda_oe);
	task automatic bit_io(input logic b, output logic r);
		#8 hold_low = ~b;
		#8 scl = 1'b1;
		r = sda_in;
		#16 scl = 1'b0;
	endtask : bit_io
	task automatic start();
		#8 hold_low = 1'b0;
		#8 scl = 1'b1;
		#8 hold_low = 1'b1;
		#8 scl = 1'b0;
	endtask : start
	task automatic stop();
		#8 hold_low = 1'b1;
		#8 scl = 1'b1;
		#8 hold_low = 1'b0;
	endtask : stop
	task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(ak, a);
	endtask : xfer
endmodule : host_link_model
`default_nettype wire

// *** test/sideband_ctrl_assertions.sv ***
// port checker for the sideband control block
// assumes a bind onto sideband_ctrl; everything is seen in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module sideband_ctrl_checker #(
	parameter longint RESET_MIN = 8
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       sda_oe,
	input  wire logic       module_select_n,
	input  wire logic       module_reset_n,
	input  wire logic       low_power_select,
	input  wire logic       attention_n,
	input  wire logic       attention_oe,
	input  wire logic       module_present_n,
	input  wire logic       module_present_oe,
	input  wire logic [3:0] lane_tx_enable,
	input  wire logic       power_limit,
	input  wire logic       data_not_ready
);
	logic [15:0] low_cnt;
	logic [7:0]  sel_hi;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// saturating, only the length of the hold matters
	always_ff @(posedge mclk or posedge rst) begin
		if (rst || module_reset_n)
			low_cnt <= 16'h0000;
		else if (low_cnt != 16'hFFFF)
			low_cnt <= low_cnt + 16'h0001;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst || !module_select_n)
			sel_hi <= 8'h00;
		else if (sel_hi != 8'hFF)
			sel_hi <= sel_hi + 8'h01;
	end
	property p_present;
		module_present_oe && !module_present_n;
	endproperty
	a_present: assert property (p_present) else $error("presence not grounded");
	property p_att_pol;
		attention_oe |-> !attention_n;
	endproperty
	a_att_pol: assert property (p_att_pol) else $error("attention level wrong");
	property p_lanes_off;
		data_not_ready |-> lane_tx_enable == 4'h0;
	endproperty
	a_lanes_off: assert property (p_lanes_off) else $error("lanes on while not ready");
	property p_low_power;
		low_power_select [*5] |-> power_limit;
	endproperty
	a_low_power: assert property (p_low_power) else $error("power not limited");
	property p_ready_att;
		$fell(data_not_ready) |-> ##[0:2] attention_oe;
	endproperty
	a_ready_att: assert property (p_ready_att) else $error("no completion attention");
	property p_short_rst;
		$rose(data_not_ready) |-> low_cnt >= RESET_MIN;
	endproperty
	a_short_rst: assert property (p_short_rst) else $error("reset from short low");
	property p_long_rst;
		low_cnt >= RESET_MIN + 8 |-> data_not_ready;
	endproperty
	a_long_rst: assert property (p_long_rst) else $error("long low ignored");
	property p_sel_quiet;
		$rose(sda_oe) |-> sel_hi < 8'd100;
	endproperty
	a_sel_quiet: assert property (p_sel_quiet) else $error("answer while deselected");
	c_ready: cover property ($fell(data_not_ready));
	c_ack: cover property ($rose(sda_oe));
	c_clear: cover property ($fell(attention_oe));
endmodule : sideband_ctrl_checker
bind sideband_ctrl sideband_ctrl_checker #(.RESET_MIN(RESET_MIN)) sideband_ctrl_checker_i (.*);
`default_nettype wire

// *** test/test_sideband_ctrl.sv ***
// self-checking bench for the sideband control block
// assumes host_link_model drives the link, short reset and init counts
`timescale 1ns/1ps
`default_nettype none
module test_sideband_ctrl;
	localparam longint RMIN = 8;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       scl;
	logic       sda_in;
	logic       sda_oe;
	logic       module_select_n = 1'b1;
	logic       module_reset_n = 1'b1;
	logic       low_power_select = 1'b0;
	logic [3:0] lane_fault = 4'h0;
	logic       attention_n;
	logic       attention_oe;
	logic       module_present_n;
	logic       module_present_oe;
	logic [3:0] lane_tx_enable;
	logic       power_limit;
	logic       data_not_ready;
	logic [7:0] d;
	int         err_count = 0;
	int         n_tests = 0;
	int         cyc = 0;
	always #4 mclk = ~mclk;
	sideband_ctrl #(.RESET_MIN(RMIN), .INIT_WAIT(20)) sideband_ctrl_i (.mclk(mclk), .rst(rst), .scl(scl),
		.sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .module_select_n(module_select_n),
		.module_reset_n(module_reset_n), .low_power_select(low_power_select), .lane_fault(lane_fault),
		.temp_in(8'h5A), .supply_in(8'hC3), .attention_n(attention_n), .attention_oe(attention_oe),
		.module_present_n(module_present_n), .module_present_oe(module_present_oe),
		.lane_tx_enable(lane_tx_enable), .power_limit(power_limit), .data_not_ready(data_not_ready));
	host_link_model host_link_model_i (.sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic wait_ready();
		for (int i = 0; i < 200 && data_not_ready !== 1'b0; i++)
			step(1);
	endtask : wait_ready
	// one frame: address, pointer, then a data byte (write) or a repeated start and one read
	task automatic frame(input logic [7:0] ofs, input logic wr, input logic [7:0] w);
		logic [7:0] x;
		logic       a1;
		logic       a2;
		logic       a3;
		host_link_model_i.start();
		host_link_model_i.xfer({sideband_pkg::DEV_ADDR, 1'b0}, 1'b1, x, a1);
		host_link_model_i.xfer(ofs, 1'b1, x, a2);
		if (wr) begin
			host_link_model_i.xfer(w, 1'b1, x, a3);
		end else begin
			host_link_model_i.start();
			host_link_model_i.xfer({sideband_pkg::DEV_ADDR, 1'b1}, 1'b1, x, a3);
			host_link_model_i.xfer(8'hFF, 1'b1, d, x[0]);
		end
		host_link_model_i.stop();
		check({5'h00, a1, a2, a3}, 8'h00);
		step(10);
	endtask : frame
	task automatic t_power_up();
		wait_ready();
		check({7'h00, data_not_ready}, 8'h00);
		check({6'h00, module_present_oe, module_present_n}, 8'h02);
		step(3);
		check({7'h00, attention_oe}, 8'h01);
		check({3'h0, power_limit, lane_tx_enable}, 8'h1F);
		module_select_n = 1'b0;
		frame(sideband_pkg::OFS_STATUS, 1'b0, 8'h00);
		check(d, 8'h02);
		frame(sideband_pkg::OFS_FLAGS, 1'b0, 8'h00);
		check(d, 8'h01);
		check({7'h00, attention_oe}, 8'h00);
		frame(sideband_pkg::OFS_TEMP, 1'b0, 8'h00);
		check(d, 8'h5A);
		frame(sideband_pkg::OFS_SUPPLY, 1'b0, 8'h00);
		check(d, 8'hC3);
		$display("test power_up done");
	endtask : t_power_up
	task automatic t_select();
		logic [7:0] x;
		logic       a;
		module_select_n = 1'b1;
		host_link_model_i.start();
		host_link_model_i.xfer({sideband_pkg::DEV_ADDR, 1'b0}, 1'b1, x, a);
		host_link_model_i.stop();
		check({7'h00, a}, 8'h01);
		step(1);
		module_select_n = 1'b0;
		$display("test select done");
	endtask : t_select
	task automatic t_controls();
		frame(sideband_pkg::OFS_CHAN, 1'b1, 8'h05);
		check({4'h0, lane_tx_enable}, 8'h0A);
		frame(sideband_pkg::OFS_POWER, 1'b1, 8'h01);
		check({7'h00, power_limit}, 8'h00);
		low_power_select = 1'b1;
		step(6);
		check({7'h00, power_limit}, 8'h01);
		low_power_select = 1'b0;
		lane_fault = 4'h4;
		step(6);
		check({7'h00, attention_oe}, 8'h01);
		frame(sideband_pkg::OFS_FLAGS, 1'b0, 8'h00);
		check(d, 8'h40);
		lane_fault = 4'h0;
		$display("test controls done");
	endtask : t_controls
	task automatic t_mreset();
		module_reset_n = 1'b0;
		step(RMIN / 2);
		module_reset_n = 1'b1;
		step(10);
		check({3'h0, data_not_ready, lane_tx_enable}, 8'h0A);
		module_reset_n = 1'b0;
		step(RMIN * 4);
		check({3'h0, data_not_ready, lane_tx_enable}, 8'h10);
		module_reset_n = 1'b1;
		wait_ready();
		step(3);
		check({7'h00, attention_oe}, 8'h01);
		frame(sideband_pkg::OFS_CHAN, 1'b0, 8'h00);
		check(d, 8'h00);
		$display("test module_reset done");
	endtask : t_mreset
	initial begin
		step(20);
		rst = 1'b0;
		t_power_up();
		t_select();
		t_controls();
		t_mreset();
		print_verdict();
	end
endmodule : test_sideband_ctrl
`default_nettype wire
